/* ack_timer_post_tx_state.sv */
// ack delay timer and post transmit radio state selection
// assumes an AXI4-Lite master and radio events on the same clock
// Summary of operation
// - wait count is high byte above low byte
// - wait count applies only when timer enabled
// - tick rate follows selected data rate
// - wait count resets to 0x0708
// - auto ack sent when timer expires
// - receive bit moves radio to receive
// - idle bit moves radio to idle
// - shutdown, then receive, idle, host request
// - forced shutdown idles radio at once
// - later host requests take effect normally
// - control register clears on reset
// - ack request moves radio to transmit
//
// Local design decision: register access over AXI4-Lite.
`default_nettype none
`timescale 1ns/1ps
module ack_timer_post_tx_state import ackt_pkg::*; #(
	parameter logic [15:0] CLK_RATE_KHZ = CLK_KHZ  // system clock in kHz
) (
	input  wire logic     clk,          // 20 MHz clock
	input  wire logic     rst,          // async reset, high
	input  wire axi_req_s bus_req,      // register bus requests
	output axi_rsp_s      bus_rsp,      // register bus answers
	input  wire logic     rx_ack_req,   // rx end of ack-request packet
	input  wire logic     tx_done,      // transmission completed
	output logic          ack_send,     // pulse: send the ack packet
	output logic          ack_busy,     // ack timer running
	output rstate_e       radio_state   // current radio state
);
	// registers
	logic [7:0]        wait_lo_q;   // wait count low byte
	logic [7:0]        wait_hi_q;   // wait count high byte
	logic [7:0]        ctrl_q;      // timer and post tx control
	logic [7:0]        auto_q;      // auto ack enable and rate
	logic              cmd_vld_q;   // host state request pending
	logic [CODE_W-1:0] cmd_q;       // requested state code
	// bus slave
	axi_rsp_s          rsp_q;       // all bus answers
	logic              aw_full_q;   // write address held
	logic              w_full_q;    // write data held
	logic [ADDR_W-1:0] waddr_q;     // held write address
	logic [7:0]        wdata_q;     // held write data, low byte
	logic              wlane_q;     // low byte lane enabled
	// timer and radio state
	logic [15:0]       cnt_q;       // ticks counted so far
	logic              run_q;       // timer running
	logic              send_q;      // ack send pulse
	rstate_e           state_q;     // radio state
	rstate_e           state_d;     // next radio state

	// wires
	logic        aw_fire;       // address taken this edge
	logic        w_fire;        // data taken this edge
	logic        ar_fire;       // read address taken
	logic        do_write;      // both halves held, commit
	logic        aw_full_d;     // next address held flag
	logic        w_full_d;      // next data held flag
	logic [4:0]  wsel;          // write target, one-hot
	logic [4:0]  rsel;          // read target, one-hot
	logic        wmap;          // write address mapped
	logic [7:0]  rbyte;         // read data byte
	logic [15:0] wait_cnt;      // full wait count
	logic        timer_en;      // ack timer enabled
	logic        auto_en;       // automatic ack enabled
	logic        done_rx;       // receive after tx
	logic        done_off;      // idle after tx
	logic        tick;          // timer tick enable
	logic        force_cmd;     // forced shutdown request
	logic        expire;        // wait count reached
	logic        ack_req;       // ack request with auto ack on
	logic [3:0]  code;          // current state code
	rstate_e     cmd_state;     // state asked by host
	logic        cmd_ok;        // host request is a known state

	// address decode to one-hot register select
	function automatic logic [4:0] decode(input logic [ADDR_W-1:0] a);
		logic [7:0] idx;
		idx = a[ADDR_W-1:IDX_LSB];
		decode = 5'h00;
		if (a[IDX_LSB-1:0] == 2'h0) begin
			decode[0] = idx == IDX_WAIT_LO;
			decode[1] = idx == IDX_WAIT_HI;
			decode[2] = idx == IDX_CTRL;
			decode[3] = idx == IDX_AUTOACK;
			decode[4] = idx == IDX_STATE;
		end
	endfunction

	// handshake terms
	assign aw_fire   = bus_req.awvalid & rsp_q.awready;
	assign w_fire    = bus_req.wvalid & rsp_q.wready;
	assign ar_fire   = bus_req.arvalid & rsp_q.arready;
	assign do_write  = aw_full_q & w_full_q & ~rsp_q.bvalid;
	assign aw_full_d = (aw_full_q | aw_fire) & ~do_write;
	assign w_full_d  = (w_full_q | w_fire) & ~do_write;
	assign wsel      = decode(waddr_q) & {5{do_write & wlane_q}};
	assign wmap      = |decode(waddr_q);
	assign rsel      = decode(bus_req.araddr);

	assign wait_cnt = {wait_hi_q, wait_lo_q};
	assign timer_en = ctrl_q[CTRL_TIMER_EN];
	assign done_rx  = ctrl_q[CTRL_DONE_RX];
	assign done_off = ctrl_q[CTRL_DONE_OFF];
	assign auto_en  = auto_q[AUTO_EN_BIT];

	// state code shown to software
	assign code = (state_q == ST_RX) ? CODE_RX :
		(state_q == ST_TX) ? CODE_TX : CODE_IDLE;

	// read mux, unmapped reads give zero
	assign rbyte = rsel[0] ? wait_lo_q :
		rsel[1] ? wait_hi_q :
		rsel[2] ? ctrl_q :
		rsel[3] ? auto_q :
		rsel[4] ? {code, code} : 8'h00;

	// write address and data capture
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			waddr_q   <= '0;
			wdata_q   <= 8'h00;
			wlane_q   <= 1'b0;
		end else begin
			aw_full_q <= aw_full_d;
			w_full_q  <= w_full_d;
			// hold address until commit
			if (aw_fire) begin
				waddr_q <= bus_req.awaddr;
			end
			// hold low byte and its strobe
			if (w_fire) begin
				wdata_q <= bus_req.wdata[7:0];
				wlane_q <= bus_req.wstrb[0];
			end
		end
	end

	// bus answers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rsp_q <= '0;
		end else begin
			rsp_q.awready <= ~aw_full_d;
			rsp_q.wready  <= ~w_full_d;
			// write answer after both halves
			if (do_write) begin
				rsp_q.bvalid <= 1'b1;
				rsp_q.bresp  <= wmap ? RESP_OK : RESP_ERR;
			end else if (bus_req.bready) begin
				rsp_q.bvalid <= 1'b0;
			end
			// read answer one cycle after address
			if (ar_fire) begin
				rsp_q.arready <= 1'b0;
				rsp_q.rvalid  <= 1'b1;
				rsp_q.rdata   <= {24'h000000, rbyte};
				rsp_q.rresp   <= (|rsel) ? RESP_OK : RESP_ERR;
			end else if (rsp_q.rvalid & bus_req.rready) begin
				rsp_q.rvalid  <= 1'b0;
				rsp_q.arready <= 1'b1;
			end else if (~rsp_q.rvalid) begin
				rsp_q.arready <= 1'b1;
			end
		end
	end
	assign bus_rsp = rsp_q;

	// configuration registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wait_lo_q <= WAIT_LO_RST;
			wait_hi_q <= WAIT_HI_RST;
			ctrl_q    <= CTRL_RST;
			auto_q    <= AUTOACK_RST;
		end else begin
			if (wsel[0]) begin
				wait_lo_q <= wdata_q;
			end
			if (wsel[1]) begin
				wait_hi_q <= wdata_q;
			end
			if (wsel[2]) begin
				ctrl_q <= wdata_q;
			end
			if (wsel[3]) begin
				auto_q <= wdata_q;
			end
		end
	end

	// host state request, one cycle pending
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmd_vld_q <= 1'b0;
			cmd_q     <= CODE_IDLE;
		end else begin
			cmd_vld_q <= wsel[4];
			if (wsel[4]) begin
				cmd_q <= wdata_q[CODE_W-1:0];
			end
		end
	end

	ack_tick_gen #(
		.CLK_RATE_KHZ (CLK_RATE_KHZ)
	) u_tick (
		.clk      (clk),
		.rst      (rst),
		.rate_sel (auto_q[RATE_W-1:0]),
		.tick     (tick)
	);

	// command decode
	assign force_cmd = cmd_vld_q & (cmd_q == CODE_FORCE);
	assign cmd_ok    = cmd_vld_q & ((cmd_q == CODE_IDLE) |
		(cmd_q == CODE_RX) | (cmd_q == CODE_TX));
	assign cmd_state = (cmd_q == CODE_RX) ? ST_RX :
		(cmd_q == CODE_TX) ? ST_TX : ST_IDLE;
	assign ack_req   = rx_ack_req & auto_en;
	assign expire    = run_q & timer_en & (cnt_q == wait_cnt);

	// ack delay timer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			run_q  <= 1'b0;
			cnt_q  <= 16'h0000;
			send_q <= 1'b0;
		end else begin
			send_q <= 1'b0;
			if (force_cmd | ~timer_en) begin
				// shutdown or disable drops the wait
				run_q <= 1'b0;
				send_q <= ack_req & ~force_cmd & ~timer_en;
			end else if (ack_req) begin
				run_q <= 1'b1;
				cnt_q <= 16'h0000;
			end else if (expire) begin
				run_q  <= 1'b0;
				send_q <= 1'b1;
			end else if (run_q & tick) begin
				cnt_q <= cnt_q + 16'h0001;
			end
		end
	end

	always_comb begin
		state_d = state_q;
		if (force_cmd) begin
			state_d = ST_IDLE;
		end else if (tx_done & done_rx) begin
			state_d = ST_RX;
		end else if (tx_done & done_off) begin
			state_d = ST_IDLE;
		end else if (cmd_ok) begin
			state_d = cmd_state;
		end else if (ack_req) begin
			state_d = ST_TX;
		end
	end

	// radio state flop
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	assign ack_send    = send_q;
	assign ack_busy    = run_q;
	assign radio_state = state_q;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_post_tx;
		tx_done & ~force_cmd;
	endsequence
	sequence s_ack_arm;
		ack_req & timer_en & ~force_cmd;
	endsequence

	wait_lo_wr_a: assert property (
		wsel[0] |=> wait_cnt[7:0] == $past(wdata_q))
		else $error("wait low byte not written");
	timer_gate_a: assert property (
		~timer_en |=> ~run_q)
		else $error("timer runs while disabled");
	tick_space_a: assert property (
		tick |=> ~tick)
		else $error("ticks back to back");
	ctrl_reset_a: assert property (
		$fell(rst) |-> ctrl_q == CTRL_RST &&
			wait_cnt == {WAIT_HI_RST, WAIT_LO_RST})
		else $error("reset values wrong");
	ack_expire_a: assert property (
		expire & ~force_cmd |=> send_q ##1 ~send_q)
		else $error("ack not sent on expiry");
	timer_start_a: assert property (
		s_ack_arm |=> run_q && cnt_q == 16'h0000)
		else $error("timer did not start");
	post_rx_a: assert property (
		s_post_tx ##0 done_rx |=> state_q == ST_RX)
		else $error("no receive after tx");
	post_idle_a: assert property (
		s_post_tx ##0 ~done_rx & done_off |=> state_q == ST_IDLE)
		else $error("no idle after tx");
	force_idle_a: assert property (
		force_cmd |=> state_q == ST_IDLE && ~run_q)
		else $error("shutdown not immediate");
	host_cmd_a: assert property (
		cmd_ok & ~force_cmd & ~tx_done |=> state_q == $past(cmd_state))
		else $error("host request ignored");
	ack_prep_a: assert property (
		ack_req & ~cmd_vld_q & ~tx_done |=> state_q == ST_TX)
		else $error("not in transmit for ack");
endmodule
`default_nettype wire

/* ackt_pkg.sv */
// constants, types and register map of the ack timer block
// assumes a 20 MHz system clock and an AXI4-Lite register master
`default_nettype none
package ackt_pkg;
	// system clock rate in kHz (20 MHz, 50 ns period)
	localparam logic [15:0] CLK_KHZ = 16'h4E20;
	localparam int ADDR_W = 10;             // byte address width
	localparam int DATA_W = 32;             // bus data width
	localparam int IDX_LSB = 2;             // word index starts here
	// register indices, byte address is four times the index
	localparam logic [7:0] IDX_WAIT_LO = 8'h50;  // wait count low byte
	localparam logic [7:0] IDX_WAIT_HI = 8'h51;  // wait count high byte
	localparam logic [7:0] IDX_CTRL    = 8'h52;  // timer and post tx ctrl
	localparam logic [7:0] IDX_AUTOACK = 8'h55;  // auto ack and rate
	localparam logic [7:0] IDX_STATE   = 8'h6C;  // radio state register
	// reset values
	localparam logic [7:0] WAIT_LO_RST = 8'h08;
	localparam logic [7:0] WAIT_HI_RST = 8'h07;
	localparam logic [7:0] CTRL_RST    = 8'h00;
	localparam logic [7:0] AUTOACK_RST = 8'h04;  // auto ack off, 100 kbps
	// field positions
	localparam int CTRL_TIMER_EN = 0;       // ack timer enable
	localparam int CTRL_DONE_OFF = 4;       // go idle after tx
	localparam int CTRL_DONE_RX  = 5;       // go receive after tx
	localparam int AUTO_EN_BIT   = 4;       // automatic ack enable
	localparam int RATE_W        = 3;       // data rate select width
	localparam int CODE_W        = 4;       // state code width
	// radio state codes, one nibble each
	localparam logic [3:0] CODE_RX    = 4'h6;
	localparam logic [3:0] CODE_IDLE  = 4'h8;
	localparam logic [3:0] CODE_TX    = 4'h9;
	localparam logic [3:0] CODE_FORCE = 4'h3;
	// timer tick rate in kHz per data rate select
	// 10,20,40,50,100,150,200,400 kbps
	localparam logic [12:0] TICK_KHZ [8] = '{13'h00B4, 13'h0168,
		13'h02D0, 13'h0384, 13'h0708, 13'h0A8C, 13'h0E10, 13'h1C20};
	// bus responses
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	// radio state, one-hot
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RX   = 3'b010,
		ST_TX   = 3'b100
	} rstate_e;
	// master to slave
	typedef struct packed {
		logic              awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic              wvalid;
		logic [DATA_W-1:0] wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [ADDR_W-1:0] araddr;
		logic              rready;
	} axi_req_s;
	// slave to master
	typedef struct packed {
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0]        rresp;
	} axi_rsp_s;
endpackage
`default_nettype wire

/* ack_tick_gen.sv */
// timer tick generator: fractional divider from the system clock
// assumes rate_sel is a register on the same clock
`default_nettype none
`timescale 1ns/1ps
module ack_tick_gen import ackt_pkg::*; #(
	parameter logic [15:0] CLK_RATE_KHZ = CLK_KHZ  // system clock in kHz
) (
	input  wire logic              clk,       // system clock
	input  wire logic              rst,       // async reset, high
	input  wire logic [RATE_W-1:0] rate_sel,  // data rate select
	output logic                   tick       // one-cycle tick enable
);
	logic [15:0] acc_q;     // phase accumulator
	logic [15:0] sum;       // accumulator plus step
	logic        wrap;      // phase passed one tick period
	logic [15:0] acc_d;     // next accumulator

	// step by the tick rate, wrap at the clock rate
	assign sum   = acc_q + {3'h0, TICK_KHZ[rate_sel]};
	assign wrap  = sum >= CLK_RATE_KHZ;
	assign acc_d = wrap ? sum - CLK_RATE_KHZ : sum;

	// accumulator and tick flop
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			acc_q <= 16'h0000;
			tick  <= 1'b0;
		end else begin
			acc_q <= acc_d;
			tick  <= wrap;
		end
	end
endmodule
`default_nettype wire

/* host_model.sv */
// host software model: register reads, writes and state polling
// assumes the AXI4-Lite channels of ackt_pkg on the same clock
`default_nettype none
`timescale 1ns/1ps
module host_model import ackt_pkg::*; (
	input  wire logic     clk,      // system clock
	input  wire axi_rsp_s bus_rsp,  // slave answers
	output axi_req_s      bus_req,  // master requests
	output logic          hang      // a bounded wait ran out
);
	logic [1:0] wr_resp;  // response of the last write
	// idle master at time zero
	initial begin
		bus_req = '0;
		hang = 1'b0;
		wr_resp = 2'h0;
	end
	// one write with all byte lanes on
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		wrs(a, d, 4'hF);
	endtask
	// one write, address and data offered together
	// starts one edge later so no strobe is set twice in a time step
	task automatic wrs(input logic [9:0] a, input logic [7:0] d,
		input logic [3:0] st);
		int n;
		n = 0;
		@(posedge clk);
		bus_req.awvalid <= 1'b1;
		bus_req.awaddr <= a;
		bus_req.wvalid <= 1'b1;
		// upper bytes carry junk the block must ignore
		bus_req.wdata <= {d, d, d, d};
		bus_req.wstrb <= st;
		bus_req.bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			// release each channel at its own take
			if (bus_req.awvalid && bus_rsp.awready) begin
				bus_req.awvalid <= 1'b0;
				bus_req.awaddr <= ~a;
			end
			if (bus_req.wvalid && bus_rsp.wready) begin
				bus_req.wvalid <= 1'b0;
				bus_req.wdata <= ~bus_req.wdata;
			end
		end while (!bus_rsp.bvalid && n < 50);
		wr_resp = bus_rsp.bresp;
		bus_req.bready <= 1'b0;
		if (n >= 50) hang <= 1'b1;
	endtask
	// one read, data and response taken at the rvalid edge
	task automatic rd(input logic [9:0] a, output logic [31:0] d,
		output logic [1:0] s);
		int n;
		n = 0;
		@(posedge clk);
		bus_req.arvalid <= 1'b1;
		bus_req.araddr <= a;
		bus_req.rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (bus_req.arvalid && bus_rsp.arready) begin
				bus_req.arvalid <= 1'b0;
				bus_req.araddr <= ~a;
			end
		end while (!bus_rsp.rvalid && n < 50);
		d = bus_rsp.rdata;
		s = bus_rsp.rresp;
		bus_req.rready <= 1'b0;
		if (n >= 50) hang <= 1'b1;
	endtask
	// wait for the state code before any write
	task automatic poll(input logic [7:0] code);
		logic [31:0] d;
		logic [1:0]  s;
		int          k;
		d = '0;
		for (k = 0; k < 20 && d[7:0] !== code; k++)
			rd({IDX_STATE, 2'b00}, d, s);
		if (d[7:0] !== code) hang <= 1'b1;
	endtask
endmodule
`default_nettype wire

/* test_ack_timer_post_tx_state.sv */
// self-checking bench for the ack timer and post tx state block
// assumes host_model drives the register bus
`default_nettype none
`timescale 1ns/1ps
module test_ack_timer_post_tx_state;
	import ackt_pkg::*;
	localparam logic [9:0] A_LO = {IDX_WAIT_LO, 2'b00};
	localparam logic [9:0] A_HI = {IDX_WAIT_HI, 2'b00};
	localparam logic [9:0] A_CT = {IDX_CTRL, 2'b00};
	localparam logic [9:0] A_AA = {IDX_AUTOACK, 2'b00};
	localparam logic [9:0] A_ST = {IDX_STATE, 2'b00};
	logic     clk = 1'b0;         // 20 MHz clock
	logic     rst = 1'b1;         // reset, high
	logic     rx_ack_req = 1'b0;  // ack request end pulse
	logic     tx_done = 1'b0;     // tx complete pulse
	axi_req_s req;                // bus requests
	axi_rsp_s rsp;                // bus answers
	logic     ack_send;           // ack send pulse
	logic     ack_busy;           // timer running
	rstate_e  radio_state;        // radio state
	logic     hang;               // host wait ran out
	int       err_count = 0;      // mismatches
	int       compares = 0;       // comparisons
	always #25 clk = ~clk;
	ack_timer_post_tx_state ack_timer_post_tx_state_inst (
		.clk(clk), .rst(rst), .bus_req(req), .bus_rsp(rsp),
		.rx_ack_req(rx_ack_req), .tx_done(tx_done), .ack_send(ack_send),
		.ack_busy(ack_busy), .radio_state(radio_state));
	host_model host_model_inst (
		.clk(clk), .bus_rsp(rsp), .bus_req(req), .hang(hang));
	// verdict and end of run
	task end_sim;
		if (err_count == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// compare and report
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	// read one register and compare data and response
	task rd_chk(input logic [9:0] a, input logic [7:0] e,
		input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  s;
		host_model_inst.rd(a, d, s);
		chk("rdata", {24'h000000, e}, d);
		chk("rresp", {30'h0, er}, {30'h0, s});
	endtask
	// write one register and compare its response
	task wr_chk(input logic [9:0] a, input logic [7:0] d,
		input logic [3:0] st, input logic [1:0] er);
		host_model_inst.wrs(a, d, st);
		chk("bresp", {30'h0, er}, {30'h0, host_model_inst.wr_resp});
	endtask
	// one-cycle pulse on tx_done or rx_ack_req
	task pulse(input bit w);
		if (w) tx_done <= 1'b1;
		else rx_ack_req <= 1'b1;
		@(posedge clk);
		tx_done <= 1'b0;
		rx_ack_req <= 1'b0;
	endtask
	// reset values and an unmapped read
	task t_reset;
		rd_chk(A_LO, WAIT_LO_RST, RESP_OK);
		rd_chk(A_HI, WAIT_HI_RST, RESP_OK);
		rd_chk(A_CT, CTRL_RST, RESP_OK);
		rd_chk(10'h3FC, 8'h00, RESP_ERR);
	endtask
	// both wait count bytes hold what was written
	task t_regs;
		wr_chk(A_LO, 8'hA5, 4'hF, RESP_OK);
		wr_chk(A_HI, 8'h5A, 4'hF, RESP_OK);
		rd_chk(A_LO, 8'hA5, RESP_OK);
		rd_chk(A_HI, 8'h5A, RESP_OK);
		// low lane off, misaligned and unmapped writes are dropped
		wr_chk(A_LO, 8'h33, 4'hE, RESP_OK);
		wr_chk(A_LO | 10'h001, 8'h33, 4'hF, RESP_ERR);
		wr_chk(10'h3FC, 8'h33, 4'hF, RESP_ERR);
		rd_chk(A_LO, 8'hA5, RESP_OK);
	endtask
	// timer off: ack at once; auto ack off: nothing
	task t_direct;
		host_model_inst.wr(A_AA, 8'h14);
		pulse(1'b0);
		#1;
		chk("ack_send", 1, ack_send);
		chk("ack_busy", 0, ack_busy);
		chk("radio_state", ST_TX, radio_state);
		host_model_inst.wr(A_AA, 8'h04);
		host_model_inst.wr(A_ST, 8'h08);
		pulse(1'b0);
		repeat (3) @(posedge clk);
		#1;
		chk("radio_state", ST_IDLE, radio_state);
	endtask
	// wait of three ticks at every data rate
	task t_delay;
		int  i;
		int  n;
		real p;
		host_model_inst.wr(A_HI, 8'h00);
		host_model_inst.wr(A_LO, 8'h03);
		host_model_inst.wr(A_CT, 8'h01);
		for (i = 0; i < 8; i++) begin
			host_model_inst.wr(A_AA, 8'h10 | 8'(i));
			pulse(1'b0);
			@(posedge clk);
			#1;
			chk("ack_busy", 1, ack_busy);
			n = 1;
			while (ack_send !== 1'b1 && n < 2000) begin
				@(posedge clk);
				#1;
				n++;
			end
			p = 20000.0 / real'(TICK_KHZ[i]);
			chk("delay_ok", 1, n >= int'(2.0 * p) - 2
				&& n <= int'(3.0 * p) + 4);
			@(posedge clk);
			#1;
			chk("ack_busy", 0, ack_busy);
		end
	endtask
	// forced shutdown stops the timer and idles the radio
	task t_abort;
		int k;
		int seen;
		seen = 0;
		host_model_inst.wr(A_LO, 8'hFF);
		host_model_inst.wr(A_AA, 8'h14);
		pulse(1'b0);
		repeat (5) @(posedge clk);
		host_model_inst.wr(A_ST, 8'h03);
		host_model_inst.poll(8'h88);
		chk("ack_busy", 0, ack_busy);
		for (k = 0; k < 4000; k++) begin
			@(posedge clk);
			#1;
			if (ack_send === 1'b1) seen = 1;
		end
		chk("no_ack", 0, seen);
	endtask
	// post tx transitions and their priority
	task t_posttx;
		host_model_inst.wr(A_CT, 8'h20);
		pulse(1'b1);
		@(posedge clk);
		#1;
		chk("radio_state", ST_RX, radio_state);
		host_model_inst.poll(8'h66);
		host_model_inst.wr(A_ST, 8'h09);
		host_model_inst.poll(8'h99);
		host_model_inst.wr(A_CT, 8'h30);
		pulse(1'b1);
		@(posedge clk);
		#1;
		chk("radio_state", ST_RX, radio_state);
		host_model_inst.poll(8'h66);
		host_model_inst.wr(A_ST, 8'h09);
		host_model_inst.wr(A_CT, 8'h10);
		host_model_inst.poll(8'h99);
		pulse(1'b1);
		@(posedge clk);
		#1;
		chk("radio_state", ST_IDLE, radio_state);
		host_model_inst.poll(8'h88);
		host_model_inst.wr(A_ST, 8'h06);
		host_model_inst.poll(8'h66);
	endtask
	// a host wait that ran out ends the run
	always @(posedge hang) begin
		err_count++;
		end_sim();
	end
	// overall time limit
	initial begin
		#4000000;
		err_count++;
		end_sim();
	end
	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_regs();
		t_direct();
		t_delay();
		t_abort();
		t_posttx();
		end_sim();
	end
endmodule
`default_nettype wire
